// >>> ctl_regs.svh
`ifndef CTL_REGS_SVH
`define CTL_REGS_SVH

// System clock rate and fixed line rate
`define CTL_CLK_KHZ      125000
`define CTL_LINE_KBPS    64
// Longest bit period rounds down to whole clock cycles
`define CTL_BIT_CYCLES   (`CTL_CLK_KHZ / `CTL_LINE_KBPS)
`define CTL_DIV_W        11
// Octet layout: bit 8 of the octet is counter value seven
`define CTL_OCTET_LAST   3'h7
`define CTL_CNT_RST      3'h0
// Switch field positions inside the synchronised switch word
`define CTL_SW_OCTET     0
`define CTL_SW_MODE_A    1
`define CTL_SW_MODE_B    2
`define CTL_SW_RST       3'h0
`define CTL_OCTET_RST    1'b0
// Data buffer toward the line transmitter
`define CTL_FIFO_DEPTH   8
`define CTL_IDLE_BIT     1'b1

`endif

// >>> ctl_pkg.sv
package ctl_pkg;

  // Operating mode chosen by the two mode switches
  typedef enum logic [1:0] {
    CTL_MODE_LOOP,
    CTL_MODE_INTERNAL,
    CTL_MODE_MIN_REMOTE,
    CTL_MODE_DUAL
  } ctl_mode_e;

  // One line bit with its octet code violation marker
  typedef struct packed {
    logic data;
    logic viol;
  } ctl_bit_s;

endpackage : ctl_pkg

// >>> ctl_fifo.sv
`timescale 1ns/1ps
module ctl_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  import ctl_pkg::*;

  // Pointers wrap naturally, so DEPTH must be a power of two
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Honest full and empty from the fill count
  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage needs no reset
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : ctl_fifo

// >>> ctl_timing_loopback.sv
// How it works
// - With octet timing on, bit 8 of every own octet carries a code violation.
// - Internal timing sends on an internal 64 kbps tick, ignoring line timing.
// - Loop timing sends our data on the recovered receive line clock.
// - Loop timing is the reset and default mode.
// - Minimum remote loopback returns raw line level at any line rate.
// - Returned level passes a polarity-restoring latch before the selector.
// - Minimum remote loopback still drains the internal stream, then discards it.
// - Line receiver keeps feeding the internal transmitter outside dual loopback.
// - Dual loopback returns internal receiver bits to the internal transmitter.
// - Dual loopback returns line bits to the line on their recovered clock.
// - Line runs at fixed 64 kbps; no rate setting exists.
`timescale 1ns/1ps
`include "ctl_regs.svh"
module ctl_timing_loopback (
  // Clock and reset
  input  wire logic          clock_i,
  input  wire logic          rstn_i,
  // Static switches
  input  wire logic          octet_timing_switch_i,
  input  wire logic          timing_mode_switch_a_i,
  input  wire logic          timing_mode_switch_b_i,
  // Line receiver, decoded bits on recovered clock
  input  wire logic          line_rx_strobe_i,
  input  wire logic          line_rx_bit_i,
  // Line receiver raw level and pair polarity
  input  wire logic          line_rx_level_i,
  input  wire logic          line_rx_pol_swap_i,
  // Internal receiver stream
  input  wire logic          dm_rx_valid_i,
  input  wire logic          dm_rx_bit_i,
  output logic               dm_rx_ready_o,
  // Internal transmitter stream
  output logic               dm_tx_valid_o,
  output logic               dm_tx_bit_o,
  // Line transmitter
  output logic               line_tx_strobe_o,
  output ctl_pkg::ctl_bit_s  line_tx_o,
  output logic               line_tx_level_o,
  output logic               line_tx_raw_o,
  // Status
  output ctl_pkg::ctl_mode_e mode_o,
  output logic               octet_en_o
);
  import ctl_pkg::*;

  logic [2:0]           sw_meta_reg;
  logic [2:0]           sw_sync_reg;
  ctl_mode_e            mode_reg;
  ctl_mode_e            mode_next;
  logic                 octet_reg;
  logic [2:0]           bit_cnt_reg;
  logic [`CTL_DIV_W-1:0] div_cnt_reg;
  logic                 int_tick;
  logic                 tx_tick;
  logic                 boundary;
  logic                 own_stream;
  logic                 stab_reg;
  logic                 fifo_in_valid;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic                 fifo_out_data;

  // Two-flop synchroniser for the switch word
  // switch sync
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sw_meta_reg <= `CTL_SW_RST;
      sw_sync_reg <= `CTL_SW_RST;
    end else begin
      sw_meta_reg <= {timing_mode_switch_b_i, timing_mode_switch_a_i, octet_timing_switch_i};
      sw_sync_reg <= sw_meta_reg;
    end
  end

  // Mode decode from the synchronised switches
  // mode decode
  always_comb begin
    unique case ({sw_sync_reg[`CTL_SW_MODE_B], sw_sync_reg[`CTL_SW_MODE_A]})
      2'b00: mode_next = CTL_MODE_LOOP;
      2'b01: mode_next = CTL_MODE_INTERNAL;
      2'b10: mode_next = CTL_MODE_MIN_REMOTE;
      2'b11: mode_next = CTL_MODE_DUAL;
    endcase
  end

  // Boundary: counter between octets and no bit going out now
  assign boundary = (bit_cnt_reg == `CTL_CNT_RST) && !tx_tick;

  // Active configuration; a dead line in loop timing holds it mid-octet
  // boundary update
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_reg  <= CTL_MODE_LOOP;
      octet_reg <= `CTL_OCTET_RST;
    end else if (boundary) begin
      mode_reg  <= mode_next;
      octet_reg <= sw_sync_reg[`CTL_SW_OCTET];
    end
  end

  // Internal bit clock, fixed rate with no setting to obey
  // fixed rate
  assign int_tick = (div_cnt_reg == `CTL_DIV_W'(`CTL_BIT_CYCLES - 1));
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cnt_reg <= '0;
    end else if (int_tick) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + `CTL_DIV_W'(1);
    end
  end

  // Transmit timing source selection
  // internal source
  always_comb begin
    unique case (mode_reg)
      CTL_MODE_INTERNAL: tx_tick = int_tick;
      default:           tx_tick = line_rx_strobe_i;
    endcase
  end

  assign own_stream = (mode_reg == CTL_MODE_LOOP) || (mode_reg == CTL_MODE_INTERNAL);

  // Octet bit position counter
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt_reg <= `CTL_CNT_RST;
    end else if (tx_tick) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // Internal stream buffered toward the line; dual loopback bypasses it
  assign fifo_in_valid = dm_rx_valid_i && (mode_reg != CTL_MODE_DUAL);
  assign dm_rx_ready_o = (mode_reg == CTL_MODE_DUAL) ? 1'b1 : fifo_in_ready;

  ctl_fifo #(
    .WIDTH (1),
    .DEPTH (`CTL_FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (dm_rx_bit_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (tx_tick),
    .out_data_o  (fifo_out_data)
  );

  // Line transmit bit; underrun sends idle ones
  // octet violation
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_tx_strobe_o <= 1'b0;
      line_tx_o        <= '0;
    end else begin
      line_tx_strobe_o <= tx_tick;
      if (tx_tick) begin
        line_tx_o.data <= own_stream ? (fifo_out_valid ? fifo_out_data : `CTL_IDLE_BIT)
                                     : line_rx_bit_i;
        line_tx_o.viol <= own_stream && octet_reg && (bit_cnt_reg == `CTL_OCTET_LAST);
      end
    end
  end

  // Stabilising latch restores polarity before the selector
  // polarity latch
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stab_reg        <= 1'b0;
      line_tx_level_o <= 1'b0;
      line_tx_raw_o   <= 1'b0;
    end else begin
      stab_reg        <= line_rx_level_i ^ line_rx_pol_swap_i;
      line_tx_level_o <= (mode_reg == CTL_MODE_MIN_REMOTE) ? stab_reg : 1'b0;
      line_tx_raw_o   <= (mode_reg == CTL_MODE_MIN_REMOTE);
    end
  end

  // Internal transmitter feed
  // receiver forward
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dm_tx_valid_o <= 1'b0;
      dm_tx_bit_o   <= 1'b0;
    end else if (mode_reg == CTL_MODE_DUAL) begin
      dm_tx_valid_o <= dm_rx_valid_i;
      dm_tx_bit_o   <= dm_rx_valid_i ? dm_rx_bit_i : dm_tx_bit_o;
    end else begin
      dm_tx_valid_o <= line_rx_strobe_i;
      dm_tx_bit_o   <= line_rx_strobe_i ? line_rx_bit_i : dm_tx_bit_o;
    end
  end

  assign mode_o     = mode_reg;
  assign octet_en_o = octet_reg;

  // Cycles since last internal tick, read only by checks
  logic [`CTL_DIV_W-1:0] gap_reg;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_reg <= '0;
    end else begin
      gap_reg <= int_tick ? '0 : gap_reg + `CTL_DIV_W'(1);
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  octet_viol_a: assert property (tx_tick && own_stream && octet_reg
      && bit_cnt_reg == `CTL_OCTET_LAST |=> line_tx_strobe_o && line_tx_o.viol)
    else $error("octet violation missing on bit 8");
  no_stray_viol_a: assert property (tx_tick && bit_cnt_reg != `CTL_OCTET_LAST
      |=> !line_tx_o.viol)
    else $error("violation outside bit 8");
  mode_decode_a: assert property (boundary && sw_sync_reg[2:1] == 2'b10
      |=> mode_reg == CTL_MODE_MIN_REMOTE)
    else $error("switch decode wrong");
  internal_tick_a: assert property (mode_reg == CTL_MODE_INTERNAL && !line_rx_strobe_i
      |-> tx_tick == int_tick)
    else $error("internal mode not on internal tick");
  loop_tick_a: assert property (mode_reg == CTL_MODE_LOOP |-> tx_tick == line_rx_strobe_i)
    else $error("loop mode not on recovered clock");
  loop_default_a: assert property (boundary && sw_sync_reg[2:1] == 2'b00
      |=> mode_reg == CTL_MODE_LOOP)
    else $error("default not loop timing");
  raw_return_a: assert property (mode_reg == CTL_MODE_MIN_REMOTE
      |=> line_tx_raw_o && line_tx_level_o == $past(stab_reg))
    else $error("raw loopback level wrong");
  stab_latch_a: assert property (1'b1
      |=> stab_reg == ($past(line_rx_level_i) ^ $past(line_rx_pol_swap_i)))
    else $error("polarity latch wrong");
  drain_discard_a: assert property (mode_reg == CTL_MODE_MIN_REMOTE
      && fifo_out_valid && tx_tick |=> !line_tx_o.viol && line_tx_raw_o)
    else $error("internal data not discarded");
  rx_forward_a: assert property (mode_reg != CTL_MODE_DUAL && line_rx_strobe_i
      |=> dm_tx_valid_o && dm_tx_bit_o == $past(line_rx_bit_i))
    else $error("line data not forwarded inward");
  dm_loop_a: assert property (mode_reg == CTL_MODE_DUAL && dm_rx_valid_i
      |=> dm_tx_valid_o && dm_tx_bit_o == $past(dm_rx_bit_i))
    else $error("internal loopback wrong");
  line_loop_a: assert property (mode_reg == CTL_MODE_DUAL && line_rx_strobe_i
      |=> line_tx_strobe_o && line_tx_o.data == $past(line_rx_bit_i))
    else $error("line loopback wrong");
  bit_rate_a: assert property (int_tick |-> gap_reg == `CTL_DIV_W'(`CTL_BIT_CYCLES - 1))
    else $error("internal bit period wrong");
  mode_change_a: assert property (mode_reg != $past(mode_reg)
      |-> $past(bit_cnt_reg) == 3'h0 && !$past(tx_tick))
    else $error("mode changed inside an octet");

  cover_minrem_c: cover property (mode_reg == CTL_MODE_MIN_REMOTE && line_rx_strobe_i);
  cover_dual_c:   cover property (mode_reg == CTL_MODE_DUAL && dm_rx_valid_i);
  cover_viol_c:   cover property (line_tx_strobe_o && line_tx_o.viol);
  cover_full_c:   cover property (!fifo_in_ready && fifo_in_valid);

endmodule : ctl_timing_loopback

// >>> ctl_line_peer.sv
`timescale 1ns/1ps
module ctl_line_peer (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  // Cycles between line bits
  input  wire logic [7:0] gap_i,
  // Line toward the block
  output logic            strobe_o,
  output logic            bit_o,
  output logic            level_o
);
  logic [7:0] cnt_reg;
  logic [7:0] pat_reg;

  always_ff @(negedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg  <= 8'h00;
      pat_reg  <= 8'h5c;
      strobe_o <= 1'b0;
      bit_o    <= 1'b0;
      level_o  <= 1'b0;
    end else begin
      level_o <= pat_reg[0] ^ cnt_reg[1];
      if (cnt_reg >= gap_i) begin
        cnt_reg  <= 8'h00;
        pat_reg  <= {pat_reg[6:0], pat_reg[7] ^ pat_reg[5]};
        strobe_o <= 1'b1;
        bit_o    <= pat_reg[7];
      end else begin
        cnt_reg  <= cnt_reg + 8'h01;
        strobe_o <= 1'b0;
        bit_o    <= ~bit_o;  // Stale bit never lingers
      end
    end
  end
endmodule : ctl_line_peer

// >>> ctl_timing_loopback_tb_top.sv
`timescale 1ns/1ps
`include "ctl_regs.svh"
module ctl_timing_loopback_tb_top;
  import ctl_pkg::*;
  logic       clock_i, rstn_i, osw, swa, swb, stb, rb, lvl, pol, dv, db;
  logic       rdy, txv, txb, lstb, llvl, lraw, oen;
  logic [7:0] gap;
  logic [2:0] hist;
  ctl_bit_s   ltx;
  ctl_mode_e  mode;
  int         mismatches, n_checks, cycles;

  ctl_timing_loopback dut_u (.clock_i, .rstn_i, .octet_timing_switch_i(osw),
    .timing_mode_switch_a_i(swa), .timing_mode_switch_b_i(swb), .line_rx_strobe_i(stb),
    .line_rx_bit_i(rb), .line_rx_level_i(lvl), .line_rx_pol_swap_i(pol),
    .dm_rx_valid_i(dv), .dm_rx_bit_i(db), .dm_rx_ready_o(rdy), .dm_tx_valid_o(txv),
    .dm_tx_bit_o(txb), .line_tx_strobe_o(lstb), .line_tx_o(ltx), .line_tx_level_o(llvl),
    .line_tx_raw_o(lraw), .mode_o(mode), .octet_en_o(oen));
  ctl_line_peer peer_u (.clock_i, .rstn_i, .gap_i(gap), .strobe_o(stb), .bit_o(rb),
    .level_o(lvl));

  // Clock at 125 MHz
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // Expected returned level, two edges late
  always @(posedge clock_i) hist <= {hist[1:0], lvl ^ pol};

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // Hang guard, tests need about 32000 cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 70000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic cmp_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_mode(input ctl_mode_e got, input ctl_mode_e exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_mode

  task automatic set_mode(input logic o, input logic a, input logic b, input ctl_mode_e m);
    ctl_mode_e old;
    int        k;
    old = mode;
    @(negedge clock_i);
    osw = o;
    swa = a;
    swb = b;
    @(negedge clock_i);
    cmp_mode(mode, old);
    k = 0;
    // Octet enable moves at the same boundary as the mode
    while ((mode !== m || oen !== o) && k < 40000) begin
      @(negedge clock_i);
      k++;
    end
    cmp_mode(mode, m);
    cmp_bit(oen, o);
  endtask : set_mode

  // Next line transmit tick, returns cycles waited
  task automatic wait_tx(output int n);
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (lstb !== 1'b1 && n < 5000);
  endtask : wait_tx

  // Eight internal bits, valid held across them
  task automatic push(input logic [7:0] v);
    @(negedge clock_i);
    dv = 1'b1;
    for (int i = 0; i < 8; i++) begin
      db = v[i];
      while (rdy !== 1'b1) @(negedge clock_i);
      @(negedge clock_i);
    end
    dv = 1'b0;
  endtask : push

  // Line bit in; outputs already stand at the negedge that shows the strobe
  task automatic line_echo(output logic b);
    do @(negedge clock_i); while (stb !== 1'b1);
    b = rb;
  endtask : line_echo

  task automatic t_loop;
    logic       b;
    logic [4:0] vc;
    int         n;
    set_mode(1'b1, 1'b0, 1'b0, CTL_MODE_LOOP);
    line_echo(b);
    cmp_bit(txv, 1'b1);
    cmp_bit(txb, b);
    cmp_bit(lstb, 1'b1);
    wait_tx(n);
    push(8'ha6);
    vc = 5'h00;
    for (int i = 0; i < 16; i++) begin
      wait_tx(n);
      cmp_bit(ltx.data, (i < 8) ? 1'(8'ha6 >> i) : `CTL_IDLE_BIT);
      vc = vc + 5'(ltx.viol);
    end
    cmp_bit(vc == 5'h02, 1'b1);
    $display("test loop done");
  endtask : t_loop

  task automatic t_minrem;
    logic b;
    int   n;
    set_mode(1'b0, 1'b0, 1'b1, CTL_MODE_MIN_REMOTE);
    line_echo(b);
    cmp_bit(txv, 1'b1);
    cmp_bit(txb, b);
    for (int i = 0; i < 8; i++) begin
      pol = i[2];
      repeat (3) @(negedge clock_i);
      cmp_bit(llvl, hist[1]);
      cmp_bit(lraw, 1'b1);
    end
    // Discarded stream must not reach the next mode
    push(8'hff);
    repeat (10) wait_tx(n);
    $display("test minimum remote done");
  endtask : t_minrem

  task automatic t_internal;
    logic b;
    int   n;
    set_mode(1'b0, 1'b1, 1'b0, CTL_MODE_INTERNAL);
    line_echo(b);
    cmp_bit(txb, b);
    wait_tx(n);
    wait_tx(n);
    cmp_bit(n == `CTL_BIT_CYCLES, 1'b1);
    push(8'h3c);
    cmp_bit(rdy, 1'b0);
    for (int i = 0; i < 9; i++) begin
      wait_tx(n);
      cmp_bit(ltx.data, (i < 8) ? 1'(8'h3c >> i) : `CTL_IDLE_BIT);
    end
    $display("test internal done");
  endtask : t_internal

  task automatic t_dual;
    logic b;
    set_mode(1'b0, 1'b1, 1'b1, CTL_MODE_DUAL);
    gap = 8'h02;
    for (int i = 0; i < 2; i++) begin
      @(negedge clock_i);
      dv = 1'b1;
      db = i[0];
      cmp_bit(rdy, 1'b1);
      @(negedge clock_i);
      dv = 1'b0;
      // Pulse stands for the cycle after the accepted bit
      cmp_bit(txv, 1'b1);
      cmp_bit(txb, i[0]);
    end
    line_echo(b);
    cmp_bit(lstb, 1'b1);
    cmp_bit(ltx.data, b);
    cmp_bit(ltx.viol, 1'b0);
    cmp_bit(txv, 1'b0);
    $display("test dual done");
  endtask : t_dual

  // Reset, then the scenarios
  initial begin
    {rstn_i, osw, swa, swb, pol, dv, db} = '0;
    gap = 8'h1e;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    repeat (19) @(negedge clock_i);
    cmp_mode(mode, CTL_MODE_LOOP);
    cmp_bit(rdy, 1'b1);
    @(negedge clock_i);
    rstn_i = 1'b1;
    $display("test reset done");
    t_loop();
    t_minrem();
    t_internal();
    t_dual();
    end_of_test();
  end
endmodule : ctl_timing_loopback_tb_top
